// ### bench/pulse_profile_step_gating_test.sv
// Self-checking bench for the pulse profile step gating block
`timescale 1ns/100ps
module pulse_profile_step_gating_test;
   logic        clock, reset, hsel, hwrite, hready, hresp;
   logic        pulse, if_sig, gate, busy, fire;
   logic [1:0]  htrans;
   logic [11:0] len;
   logic [31:0] haddr, hwdata, hrdata, rd, t0;
   int          miscompares, checks, gate_clks;
   logic [31:0] bad [4][3] = '{'{0, 0, 1}, '{100, 0, 1},
                               '{1, 1000000, 1}, '{1, 0, 0}};
   pulse_profile_step_gating u_pulse_profile_step_gating (
      .clock_i(clock), .reset_i(reset), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .pulse_i(pulse), .if_i(if_sig), .gate_o(gate), .busy_o(busy));
   pulse_source u_pulse_source (
      .clock_i(clock), .reset_i(reset), .fire_i(fire), .len_i(len),
      .pulse_o(pulse), .if_o(if_sig));
   always @(posedge clock)
      if (gate === 1'b1)
         gate_clks++;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Bounded wait for one rising edge with ready high
   task automatic rdy;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (hready !== 1'b1) begin
         miscompares++;
         conclude;
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      rdy;
      htrans <= 2'b00;
      hwdata <= wd;
      rdy;
      rd = hrdata;
   endtask
   task automatic rdm(input string nm, input logic [7:0] a,
                      input logic [31:0] m, exp);
      bus(1'b0, a, 32'h0);
      chk(nm, rd & m, exp);
   endtask
   task automatic wait_busy(input logic want);
      int n;
      n = 0;
      while (busy !== want) begin
         @(posedge clock);
         n++;
         if (n > 20000) begin
            miscompares++;
            conclude;
         end
      end
   endtask
   // Parameters always go in as a set before the start bit
   task automatic run(input logic [31:0] st, s0, cp, lim, ctl,
                      input logic [11:0] n);
      int k;
      // A new pulse needs the last one gone, or no rising edge is seen
      k = 0;
      while (pulse !== 1'b0) begin
         @(posedge clock);
         k++;
         if (k > 20000) begin
            miscompares++;
            conclude;
         end
      end
      bus(1'b1, profile_pkg::OFS_STEPS, st);
      bus(1'b1, profile_pkg::OFS_START, s0);
      bus(1'b1, profile_pkg::OFS_CPS, cp);
      bus(1'b1, profile_pkg::OFS_LIMIT, lim);
      bus(1'b1, profile_pkg::OFS_CTRL, ctl);
      wait_busy(1'b1);
      gate_clks = 0;
      len <= n;
      fire <= 1'b1; // Single shots, no averaging to bound
      @(posedge clock);
      fire <= 1'b0;
   endtask
   task automatic t_reset;
      chk("gate", {31'h0, gate}, 32'h0);
      chk("busy", {31'h0, busy}, 32'h0);
      chk("resp", {30'h0, hresp, hready}, 32'h1);
      rdm("ctrl", profile_pkg::OFS_CTRL, 32'hff, 32'h90);
      bus(1'b1, 8'h3c, 32'hffffffff);
      rdm("unmapped", 8'h3c, 32'hffffffff, 32'h0);
   endtask
   task automatic t_walk;
      run(2, 1, 3, 0, 32'h93, 10);
      wait_busy(1'b0);
      rdm("status", profile_pkg::OFS_STATUS, 32'h7f0f, 32'h20a);
      rdm("cycles", profile_pkg::OFS_RES_C, 32'hffffffff, 6);
      chk("gate_clks", gate_clks, 24);
      bus(1'b1, profile_pkg::OFS_TIDX, 0);
      bus(1'b0, profile_pkg::OFS_TTIME, 0);
      t0 = rd;
      bus(1'b1, profile_pkg::OFS_TIDX, 1);
      bus(1'b0, profile_pkg::OFS_TTIME, 0);
      chk("step_time", rd - t0, 480);
      rdm("dur", profile_pkg::OFS_TDUR,
          32'hf0ffffff, 32'h9000000c);
      bus(1'b1, profile_pkg::OFS_CTRL, 32'h50);
      rdm("digits", profile_pkg::OFS_TDUR,
          32'hf0000000, 32'h50000000);
   endtask
   task automatic t_maxima;
      run(99, 999999, 999999, 0, 32'h93, 200);
      rdm("man_used", profile_pkg::OFS_STATUS,
          32'h9, 32'h9);
      wait_busy(1'b0);
      rdm("zero", profile_pkg::OFS_STATUS, 32'h6, 32'h6);
      rdm("ticks", profile_pkg::OFS_RES_T, 32'hffffffff, 0);
      rdm("last", profile_pkg::OFS_LASTP, 32'hffffffff, 200);
   endtask
   // Each set holds one value just outside its accepted range
   task automatic t_invalid;
      for (int i = 0; i < 4; i++) begin
         run(bad[i][0], bad[i][1], bad[i][2], 0, 32'h93, 200);
         rdm("man_off", profile_pkg::OFS_STATUS, 32'h8, 0);
         wait_busy(1'b0);
         rdm("dflt", profile_pkg::OFS_STATUS, 32'h7f06, 32'h2002);
         // 32 default steps of (200 - 1) >> 5 cycles each
         rdm("dflt_cyc", profile_pkg::OFS_RES_C, 32'hffffffff, 192);
      end
   endtask
   task automatic t_limits;
      run(5, 0, 4, 10, 32'h9b, 40);
      wait_busy(1'b0);
      rdm("cyc_lim", profile_pkg::OFS_STATUS, 32'h7f06, 32'h202);
      run(5, 0, 4, 42, 32'h97, 40);
      wait_busy(1'b0);
      rdm("time_lim", profile_pkg::OFS_STATUS, 32'h7f06, 32'h202);
      bus(1'b0, profile_pkg::OFS_ACT_T1, 0);
      chk("stop_ns", 32'(rd > 1640 && rd < 1720), 1);
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      {reset, hsel, hwrite, fire} = 4'h8;
      {htrans, len, haddr, hwdata} = '0;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset;
      t_walk;
      t_maxima;
      t_invalid;
      t_limits;
      conclude;
   end
endmodule

// ### bench/pulse_source.sv
// Pulse envelope and IF source standing in for the measured signal
`timescale 1ns/100ps
module pulse_source (
   input  wire logic        clock_i, // Block clock
   input  wire logic        reset_i, // Reset, high
   input  wire logic        fire_i,  // Start one pulse
   input  wire logic [11:0] len_i,   // IF cycles in the pulse
   output logic             pulse_o, // Pulse envelope
   output logic             if_o     // IF signal, four clocks a cycle
);
   logic [13:0] cnt;
   // IF stays low outside the pulse, as a gated signal would
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pulse_o <= 1'b0;
         if_o <= 1'b0;
         cnt <= 14'h0;
      end else if (fire_i) begin
         pulse_o <= 1'b1;
         cnt <= 14'h0;
      end else if (pulse_o) begin
         cnt <= cnt + 14'h1;
         if_o <= cnt[1];
         if (cnt == {len_i, 2'b00})
            pulse_o <= 1'b0;
      end else
         if_o <= 1'b0;
   end
endmodule

// ### src/bit_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module bit_sync #(
   parameter int W = 1                 // Number of bits
) (
   input  wire logic         clock_i,  // Block clock
   input  wire logic         reset_i,  // Asynchronous reset, high
   input  wire logic [W-1:0] d_i,      // Asynchronous levels
   output logic      [W-1:0] q_o       // Synchronised levels
);
   logic [W-1:0] meta;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// ### src/profile_pkg.sv
// Shared constants and types for the pulse profile step gating block
package profile_pkg;
   // Clock rate and the tick length derived from it
   localparam int          CLK_MHZ    = 25;
   localparam logic [31:0] CLK_NS     = 32'(1000 / CLK_MHZ);
   // Counter widths
   localparam int          CYC_W      = 28;
   localparam int          TICK_W     = 24;
   localparam int          STEP_W     = 7;
   // Accepted ranges of the manual step parameters
   localparam logic [6:0]  STEPS_MIN  = 7'h01;
   localparam logic [6:0]  STEPS_MAX  = 7'h63;
   localparam logic [27:0] START_MAX  = 28'h00f423f;
   localparam logic [27:0] CPS_MIN    = 28'h0000001;
   localparam logic [27:0] CPS_MAX    = 28'h00f423f;
   // Default profile: 2**DEF_STEPS_LOG2 steps from cycle zero
   localparam int          DEF_STEPS_LOG2 = 5;
   localparam logic [6:0]  DEF_STEPS  = 7'h20;
   localparam logic [27:0] DEF_START  = 28'h0000000;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_STEPS  = 8'h04;
   localparam logic [7:0]  OFS_START  = 8'h08;
   localparam logic [7:0]  OFS_CPS    = 8'h0c;
   localparam logic [7:0]  OFS_LIMIT  = 8'h10;
   localparam logic [7:0]  OFS_STATUS = 8'h14;
   localparam logic [7:0]  OFS_ACT_T0 = 8'h18;
   localparam logic [7:0]  OFS_ACT_T1 = 8'h1c;
   localparam logic [7:0]  OFS_RES_C  = 8'h20;
   localparam logic [7:0]  OFS_RES_T  = 8'h24;
   localparam logic [7:0]  OFS_TIDX   = 8'h28;
   localparam logic [7:0]  OFS_TTIME  = 8'h2c;
   localparam logic [7:0]  OFS_TDUR   = 8'h30;
   localparam logic [7:0]  OFS_LASTP  = 8'h34;
   // Control register fields and reset values
   localparam int          CTRL_GO    = 0;
   localparam int          CTRL_MAN   = 1;
   localparam int          CTRL_MODE  = 2;
   localparam int          CTRL_DIG   = 4;
   localparam logic [3:0]  DIG_RST    = 4'h9;
   localparam int          TDUR_DIG   = 28;
   typedef enum logic [1:0] {
      GATE_NONE = 2'h0,
      GATE_TIME = 2'h1,
      GATE_CYC  = 2'h2
   } gate_mode_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_ARM  = 4'b0010,
      S_RUN  = 4'b0100,
      S_DONE = 4'b1000
   } state_t;
   typedef struct packed {
      logic [STEP_W-1:0] steps;
      logic [CYC_W-1:0]  start_cyc;
      logic [CYC_W-1:0]  cps;
   } prof_cfg_t;
endpackage

// ### src/pulse_profile_step_gating.sv
// Step-wise IF-cycle gating sequencer for pulse frequency profiling
// How it works
// RULE1: Default profile gates fewer cycles than pulse; the code gates 32 cycles when the last pulse was 32 cycles or fewer
// RULE2: Gate end past pulse end gives zero
// RULE3: Gate back edge settable as IF-cycle count
// RULE4: Set maximum gate time applies to profiling
// RULE5: Controller programs all three step parameters
// RULE6: Step count accepted from 1 to 99
// RULE7: Start cycle 0 to 999999, first step there
// RULE8: Cycles per step accepted 1 to 999999
// RULE9: Controller bounds averages times maximum time; the block has no averaging, each run gates a single pulse
// RULE10: Each entry tagged with its step start
// RULE11: Table holds raw unfiltered per-step values
// RULE12: Report achieved start and stop times
// RULE13: Printed digits follow selected resolution
// RULE14: Any invalid manual parameter selects defaults
// RULE15: Step k starts at start plus k*step
`timescale 1ns/100ps
module pulse_profile_step_gating #(
   parameter int TABLE_DEPTH = 99      // Profile table entries
) (
   input  wire logic        clock_i,   // 25 MHz clock
   input  wire logic        reset_i,   // Asynchronous reset, high
   input  wire logic        hsel_i,    // AHB slave select
   input  wire logic [31:0] haddr_i,   // AHB address
   input  wire logic [1:0]  htrans_i,  // AHB transfer type
   input  wire logic        hwrite_i,  // AHB write
   input  wire logic [2:0]  hsize_i,   // AHB size, words only
   input  wire logic [31:0] hwdata_i,  // AHB write data
   input  wire logic        hready_i,  // AHB bus ready
   output logic      [31:0] hrdata_o,  // AHB read data
   output logic             hreadyout_o, // AHB slave ready
   output logic             hresp_o,   // AHB response, OKAY
   input  wire logic        pulse_i,   // Pulse envelope pin
   input  wire logic        if_i,      // Down-converted IF pin
   output logic             gate_o,    // Step gate open
   output logic             busy_o     // Profile run in progress
);
   localparam int CW = profile_pkg::CYC_W;
   localparam int TW = profile_pkg::TICK_W;
   localparam int SW = profile_pkg::STEP_W;

   if (TABLE_DEPTH < 99 || TABLE_DEPTH > 127) begin : g_depth_check
      $error("TABLE_DEPTH must lie in 99..127");
   end

   logic [1:0]              sync_q;
   logic                    pulse_s, if_s, pulse_d, if_d;
   logic                    pulse_rise, pulse_fall, if_rise;
   logic                    wr_pend;
   logic [7:0]              wr_addr;
   logic                    take;
   logic [31:0]             rd_val;
   logic                    start_req, manual_en;
   profile_pkg::gate_mode_t gate_mode, run_mode;
   logic [3:0]              digits;
   profile_pkg::prof_cfg_t  cfg, eff, def_cfg;
   logic [CW-1:0]           gate_limit, run_limit;
   logic [SW-1:0]           tbl_idx;
   profile_pkg::state_t     state, next_state;
   logic                    launch, manual_ok, manual_used;
   logic [TW-1:0]           ticks, step_t0, act_t0, act_t1;
   logic [CW-1:0]           if_cnt, boundary, last_pulse;
   logic [CW-1:0]           res_cyc, res_ticks, def_cps;
   logic [SW-1:0]           step_idx, steps_done;
   logic                    at_bound, last_edge, lim_hit;
   logic                    pulse_end, run_end, zero_res;
   logic [TW-1:0]           tag_mem [TABLE_DEPTH];
   logic [TW-1:0]           dur_mem [TABLE_DEPTH];

   bit_sync #(.W(2)) u_sync (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .d_i     ({pulse_i, if_i}),
      .q_o     (sync_q)
   );
   assign pulse_s = sync_q[1];
   assign if_s    = sync_q[0];

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pulse_d <= 1'b0;
         if_d    <= 1'b0;
      end else begin
         pulse_d <= pulse_s;
         if_d    <= if_s;
      end
   end
   assign pulse_rise = pulse_s & ~pulse_d;
   assign pulse_fall = ~pulse_s & pulse_d;
   assign if_rise    = if_s & ~if_d;

   // Zero wait state slave; writes land in the data phase
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign take        = hsel_i & hready_i & htrans_i[1];

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         wr_pend  <= 1'b0;
         wr_addr  <= 8'h00;
         hrdata_o <= 32'h0000_0000;
      end else begin
         wr_pend <= take & hwrite_i;
         if (take) begin
            wr_addr <= haddr_i[7:0];
         end
         if (take & ~hwrite_i) begin
            hrdata_o <= rd_val;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         start_req  <= 1'b0;
         manual_en  <= 1'b0;
         gate_mode  <= profile_pkg::GATE_NONE;
         digits     <= profile_pkg::DIG_RST;
         cfg        <= '0;
         gate_limit <= '0;
         tbl_idx    <= '0;
      end else begin
         start_req <= 1'b0;
         if (wr_pend) begin
            case (wr_addr)
               profile_pkg::OFS_CTRL: begin
                  start_req <= hwdata_i[profile_pkg::CTRL_GO];
                  manual_en <= hwdata_i[profile_pkg::CTRL_MAN];
                  gate_mode <= profile_pkg::gate_mode_t'(
                     hwdata_i[profile_pkg::CTRL_MODE +: 2]);
                  digits    <= hwdata_i[profile_pkg::CTRL_DIG +: 4];
               end
               profile_pkg::OFS_STEPS: cfg.steps <= hwdata_i[SW-1:0];
               profile_pkg::OFS_START: cfg.start_cyc <= hwdata_i[CW-1:0];
               profile_pkg::OFS_CPS:   cfg.cps <= hwdata_i[CW-1:0];
               profile_pkg::OFS_LIMIT: gate_limit <= hwdata_i[CW-1:0];
               profile_pkg::OFS_TIDX:  tbl_idx <= hwdata_i[SW-1:0];
               default: ;
            endcase
         end
      end
   end

   // Table and status views; an unmapped address reads zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (haddr_i[7:0])
         profile_pkg::OFS_CTRL:
            rd_val = {24'h0, digits, gate_mode, manual_en, 1'b0};
         profile_pkg::OFS_STEPS:  rd_val = {25'h0, cfg.steps};
         profile_pkg::OFS_START:  rd_val = {4'h0, cfg.start_cyc};
         profile_pkg::OFS_CPS:    rd_val = {4'h0, cfg.cps};
         profile_pkg::OFS_LIMIT:  rd_val = {4'h0, gate_limit};
         profile_pkg::OFS_STATUS:
            rd_val = {17'h0, steps_done, 4'h0, manual_used, zero_res,
                      state[3], busy_o};
         profile_pkg::OFS_ACT_T0:                              // [RULE12]
            rd_val = 32'({8'h00, act_t0} * profile_pkg::CLK_NS);
         profile_pkg::OFS_ACT_T1:                              // [RULE12]
            rd_val = 32'({8'h00, act_t1} * profile_pkg::CLK_NS);
         profile_pkg::OFS_RES_C:  rd_val = {4'h0, res_cyc};
         profile_pkg::OFS_RES_T:  rd_val = {4'h0, res_ticks};
         profile_pkg::OFS_TIDX:   rd_val = {25'h0, tbl_idx};
         profile_pkg::OFS_TTIME:                               // [RULE10]
            if (int'(tbl_idx) < TABLE_DEPTH) begin
               rd_val = 32'({8'h00, tag_mem[tbl_idx]} * profile_pkg::CLK_NS);
            end
         profile_pkg::OFS_TDUR:                        // [RULE11] [RULE13]
            if (int'(tbl_idx) < TABLE_DEPTH) begin
               rd_val = {digits, 4'h0, dur_mem[tbl_idx]};
            end
         profile_pkg::OFS_LASTP:  rd_val = {4'h0, last_pulse};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // All three manual values must be legal, else defaults apply
   assign manual_ok = manual_en                                // [RULE14]
      && cfg.steps >= profile_pkg::STEPS_MIN                   // [RULE6]
      && cfg.steps <= profile_pkg::STEPS_MAX
      && cfg.start_cyc <= profile_pkg::START_MAX               // [RULE7]
      && cfg.cps >= profile_pkg::CPS_MIN                       // [RULE8]
      && cfg.cps <= profile_pkg::CPS_MAX;

   // Defaults spread the last pulse minus one cycle over fixed steps
   always_comb begin
      def_cps = '0;
      if (last_pulse > 28'h0000001) begin                      // [RULE1]
         def_cps = (last_pulse - 28'h0000001)
                   >> profile_pkg::DEF_STEPS_LOG2;
      end
      if (def_cps == '0) begin
         def_cps = 28'h0000001;
      end
      def_cfg.steps     = profile_pkg::DEF_STEPS;
      def_cfg.start_cyc = profile_pkg::DEF_START;
      def_cfg.cps       = def_cps;
   end

   assign launch = start_req
                   & (state == profile_pkg::S_IDLE
                      | state == profile_pkg::S_DONE);
   assign busy_o = state[1] | state[2];

   always_comb begin
      next_state = state;
      unique case (state)
         profile_pkg::S_IDLE, profile_pkg::S_DONE:
            if (launch) begin
               next_state = profile_pkg::S_ARM;
            end
         profile_pkg::S_ARM:
            if (pulse_rise) begin
               next_state = profile_pkg::S_RUN;
            end
         profile_pkg::S_RUN:
            if (run_end) begin
               next_state = profile_pkg::S_DONE;
            end
         default: next_state = profile_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state <= profile_pkg::S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Settings are frozen at launch so a run sees one consistent set
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         eff         <= '0;
         manual_used <= 1'b0;
         run_mode    <= profile_pkg::GATE_NONE;
         run_limit   <= '0;
      end else if (launch) begin
         eff         <= manual_ok ? cfg : def_cfg;             // [RULE14]
         manual_used <= manual_ok;
         run_mode    <= gate_mode;                      // [RULE3] [RULE4]
         run_limit   <= gate_limit;
      end
   end

   // Time zero is the pulse leading edge
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ticks  <= '0;
         if_cnt <= '0;
      end else if (state == profile_pkg::S_ARM) begin
         ticks  <= '0;
         if_cnt <= '0;
      end else if (state == profile_pkg::S_RUN) begin
         ticks <= ticks + 24'h000001;
         if (if_rise) begin
            if_cnt <= if_cnt + 28'h0000001;
         end
      end
   end

   assign at_bound  = (state == profile_pkg::S_RUN) & if_rise
                      & (if_cnt == boundary);                  // [RULE15]
   assign last_edge = at_bound & (step_idx == eff.steps);
   assign lim_hit   = (state == profile_pkg::S_RUN) & (
      (run_mode == profile_pkg::GATE_TIME
       & {4'h0, ticks} >= run_limit)                           // [RULE4]
      | (run_mode == profile_pkg::GATE_CYC & if_rise
         & if_cnt >= run_limit));                              // [RULE3]
   assign pulse_end = (state == profile_pkg::S_RUN) & pulse_fall;
   assign run_end   = last_edge | lim_hit | pulse_end;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         step_idx   <= '0;
         steps_done <= '0;
         boundary   <= '0;
         step_t0    <= '0;
         gate_o     <= 1'b0;
      end else if (launch) begin
         step_idx   <= '0;
         steps_done <= '0;
         boundary   <= manual_ok ? cfg.start_cyc                // [RULE7]
                                 : profile_pkg::DEF_START;
         gate_o     <= 1'b0;
      end else if (at_bound) begin
         if (step_idx != '0) begin
            steps_done <= step_idx;
         end
         if (!last_edge && !lim_hit) begin
            step_idx <= step_idx + 7'h01;
            boundary <= boundary + eff.cps;                    // [RULE15]
            step_t0  <= ticks;
         end
         // A step that opens as the pulse falls would never close
         gate_o <= !last_edge && !lim_hit && !pulse_end;
      end else if (run_end) begin
         gate_o <= 1'b0;
      end
   end

   // One tag and one raw duration per step, no smoothing
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < TABLE_DEPTH; i++) begin
            tag_mem[i] <= '0;
            dur_mem[i] <= '0;
         end
      end else if (at_bound) begin
         if (step_idx != '0) begin
            dur_mem[step_idx - 7'h01] <= ticks - step_t0;      // [RULE11]
         end
         if (!last_edge && !lim_hit) begin
            tag_mem[step_idx] <= ticks;                        // [RULE10]
         end
      end
   end

   // A gate still open at the trailing edge spoils the result
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         act_t0    <= '0;
         act_t1    <= '0;
         res_cyc   <= '0;
         res_ticks <= '0;
         zero_res  <= 1'b0;
      end else if (launch) begin
         res_cyc   <= '0;
         res_ticks <= '0;
         zero_res  <= 1'b0;
      end else if (pulse_end && !last_edge) begin
         res_cyc   <= '0;                                      // [RULE2]
         res_ticks <= '0;
         zero_res  <= 1'b1;
      end else if (at_bound) begin
         if (step_idx == '0) begin
            act_t0 <= ticks;                                   // [RULE12]
         end else begin
            act_t1    <= ticks;                                // [RULE12]
            res_cyc   <= boundary - eff.start_cyc;
            res_ticks <= {4'h0, ticks - act_t0};
         end
      end else if (lim_hit) begin
         // A limit closes the gate, so that is the achieved stop
         act_t1 <= ticks;                                      // [RULE12]
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         last_pulse <= '0;
      end else if (pulse_end) begin
         last_pulse <= if_cnt + {27'h0, if_rise};              // [RULE1]
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   property p_steps_range;
      busy_o |-> eff.steps >= profile_pkg::STEPS_MIN
                 && eff.steps <= profile_pkg::STEPS_MAX;
   endproperty
   a_steps_range: assert property (p_steps_range) // [RULE6]
      else $error("step count out of range");

   property p_cps_range;
      busy_o |-> eff.cps >= profile_pkg::CPS_MIN
                 && eff.cps <= profile_pkg::CPS_MAX;
   endproperty
   a_cps_range: assert property (p_cps_range) // [RULE8]
      else $error("step size out of range");

   property p_manual_pick;
      launch |=> (manual_used == $past(manual_ok))
                 && (manual_used || eff.steps == profile_pkg::DEF_STEPS);
   endproperty
   a_manual_pick: assert property (p_manual_pick) // [RULE14]
      else $error("wrong parameter set chosen");

   property p_first_step;
      at_bound && step_idx == '0 && !lim_hit && !last_edge && !pulse_end
         |-> if_cnt == eff.start_cyc ##1 step_idx == 7'h01 && gate_o;
   endproperty
   a_first_step: assert property (p_first_step) // [RULE7]
      else $error("first step not on start cycle");

   property p_boundary;
      busy_o |-> boundary == CW'(eff.start_cyc
                                 + CW'(step_idx) * eff.cps);
   endproperty
   a_boundary: assert property (p_boundary) // [RULE15]
      else $error("step boundary misplaced");

   property p_zero;
      pulse_end && !last_edge |=> zero_res && res_cyc == '0
                                  && res_ticks == '0;
   endproperty
   a_zero: assert property (p_zero) // [RULE2]
      else $error("late gate did not give zero");

   property p_time_limit;
      state == profile_pkg::S_RUN && run_mode == profile_pkg::GATE_TIME
         && {4'h0, ticks} >= run_limit |=> state == profile_pkg::S_DONE
                                           && !gate_o;
   endproperty
   a_time_limit: assert property (p_time_limit) // [RULE4]
      else $error("time limit did not end gate");

   property p_cyc_limit;
      state == profile_pkg::S_RUN && run_mode == profile_pkg::GATE_CYC
         && if_rise && if_cnt >= run_limit |=> !busy_o;
   endproperty
   a_cyc_limit: assert property (p_cyc_limit) // [RULE3]
      else $error("cycle limit did not end gate");

   property p_default_short;
      state == profile_pkg::S_RUN && !manual_used
         && last_pulse > 28'h0000020
         |-> 35'(eff.steps) * 35'(eff.cps) < 35'(last_pulse);
   endproperty
   a_default_short: assert property (p_default_short) // [RULE1]
      else $error("default profile too long");

   property p_tag_start;
      state == profile_pkg::S_DONE && steps_done != '0
         |-> tag_mem[0] == act_t0;
   endproperty
   a_tag_start: assert property (p_tag_start) // [RULE10]
      else $error("first tag is not the start time");
endmodule
